// [verilog/supervisor_consts.vh]
// Timing constants and encodings for the reset supervisor
`ifndef SUPERVISOR_CONSTS_VH
`define SUPERVISOR_CONSTS_VH

// ----------------------------------------------------------------
// Clock and timebase
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 50
// One timebase tick per this many clock cycles
`define TICK_DIV 20
`define TICK_DIV_W 5

// ----------------------------------------------------------------
// Hold and watchdog periods, in timebase ticks
// ----------------------------------------------------------------
`define HOLD_TICKS 140
`define WDOG_TICKS 1600
`define CNT_W 16
// Open kick input is serviced at seven eighths of the period
`define WDOG_OPEN_TICKS ((`WDOG_TICKS * 7) / 8)

// ----------------------------------------------------------------
// Manual reset glitch filter and pullup one-shot
// ----------------------------------------------------------------
`define MR_GLITCH_NS 100
`define MR_FILT_CYC (((`MR_GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 1)
`define ONESHOT_NS 2000
`define ONESHOT_CYC (`ONESHOT_NS / `CLK_PERIOD_NS)
`define SHORT_W 8

// ----------------------------------------------------------------
// Reset state machine encodings
// ----------------------------------------------------------------
`define ST_RUN 2'h0
`define ST_ASSERT 2'h1
`define ST_HOLD 2'h2

`endif

// [verilog/reset_line_pullup.v]
// Bidirectional reset line driver with transition flip-flop and active pullup one-shot
`include "supervisor_consts.vh"

module reset_line_pullup (
    ref_clk,
    reset,
    drive_low,
    line_low_in,
    line_above_enable,
    line_above_upper,
    line_out,
    line_oe,
    active_pullup_on,
    passive_pullup_on,
    transition_armed
);
    input wire ref_clk;
    input wire reset;
    input wire drive_low;
    input wire line_low_in;
    input wire line_above_enable;
    input wire line_above_upper;
    output reg line_out;
    output reg line_oe;
    output reg active_pullup_on;
    output reg passive_pullup_on;
    output reg transition_armed;

    reg [`SHORT_W-1:0] shot_q;
    wire shot_start;

    // Full-width copy so the one-shot load is cut to the counter on purpose
    localparam [31:0] SHOT_LOAD = `ONESHOT_CYC;

    // ----------------------------------------------------------------
    // Line driver, transition flip-flop and one-shot
    // ----------------------------------------------------------------
    assign shot_start = transition_armed && line_above_enable && !line_above_upper;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            line_out <= 1'b0;
            line_oe <= 1'b1;
            passive_pullup_on <= 1'b0;
            transition_armed <= 1'b1;
            active_pullup_on <= 1'b0;
            shot_q <= 8'h00;
        end else begin
            line_out <= 1'b0;
            line_oe <= drive_low;
            passive_pullup_on <= !drive_low;
            if (!line_above_enable || line_low_in) begin
                transition_armed <= 1'b1;
            end else if (shot_start) begin
                transition_armed <= 1'b0;
            end
            if (shot_start && !drive_low) begin
                active_pullup_on <= 1'b1;
                shot_q <= SHOT_LOAD[`SHORT_W-1:0];
            end else if (active_pullup_on) begin
                // Off at the upper level or when the one-shot ends
                if (line_above_upper || shot_q == 8'h01 || drive_low || !line_above_enable) begin
                    active_pullup_on <= 1'b0;
                    shot_q <= 8'h00;
                end else begin
                    shot_q <= shot_q - 8'h01;
                end
            end
        end
    end
endmodule // reset_line_pullup

// [verilog/supervisor_reset_watchdog.v]
// Reset supervisor: undervoltage, manual reset, watchdog and bidirectional reset line
`include "supervisor_consts.vh"

module supervisor_reset_watchdog (
    ref_clk,
    reset,
    supply_low,
    manual_reset_n,
    watchdog_kick_in,
    kick_driven,
    line_low_in,
    line_above_enable,
    line_above_upper,
    reset_n_out,
    reset_out,
    line_out,
    line_oe,
    active_pullup_on,
    passive_pullup_on,
    transition_armed
);
    input wire ref_clk;
    input wire reset;
    input wire supply_low;
    input wire manual_reset_n;
    input wire watchdog_kick_in;
    input wire kick_driven;
    input wire line_low_in;
    input wire line_above_enable;
    input wire line_above_upper;
    output reg reset_n_out;
    output reg reset_out;
    output wire line_out;
    output wire line_oe;
    output wire active_pullup_on;
    output wire passive_pullup_on;
    output wire transition_armed;

    localparam ST_RUN = `ST_RUN;
    localparam ST_ASSERT = `ST_ASSERT;
    localparam ST_HOLD = `ST_HOLD;

    // Limits kept 32 bits wide; each compare takes an exact slice of them
    localparam [31:0] TICK_LAST = `TICK_DIV - 1;
    localparam [31:0] MR_FILT_LAST = `MR_FILT_CYC;
    localparam [31:0] WDOG_LIMIT = `WDOG_TICKS;
    localparam [31:0] WDOG_OPEN_LIMIT = `WDOG_OPEN_TICKS;
    localparam [31:0] HOLD_LIMIT = `HOLD_TICKS;

    reg [`TICK_DIV_W-1:0] div_q;
    reg tick_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [`CNT_W-1:0] hold_q;
    reg [`CNT_W-1:0] wdog_q;
    reg [`SHORT_W-1:0] mr_filt_q;
    reg mr_low_q;
    reg kick_prev_q;
    reg drive_low_q;
    reg line_mask_q;
    wire kick_edge;
    wire wdog_expired;
    wire src_active;

    // ----------------------------------------------------------------
    // Timebase divider
    // ----------------------------------------------------------------
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div_q <= 5'h00;
            tick_q <= 1'b0;
        end else if (div_q == TICK_LAST[`TICK_DIV_W-1:0]) begin
            div_q <= 5'h00;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 5'h01;
            tick_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Manual reset glitch filter
    // ----------------------------------------------------------------
    // A low must persist longer than the glitch width before it counts;
    // release is immediate so the hold timer starts from the true edge.
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mr_filt_q <= 8'h00;
            mr_low_q <= 1'b0;
        end else if (manual_reset_n) begin
            mr_filt_q <= 8'h00;
            mr_low_q <= 1'b0;
        end else if (mr_filt_q == MR_FILT_LAST[`SHORT_W-1:0]) begin
            mr_low_q <= 1'b1;
        end else begin
            mr_filt_q <= mr_filt_q + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    assign kick_edge = kick_driven && (watchdog_kick_in != kick_prev_q);
    assign wdog_expired = kick_driven && (wdog_q >= WDOG_LIMIT[`CNT_W-1:0]);

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            kick_prev_q <= 1'b0;
            wdog_q <= 16'h0000;
        end else begin
            kick_prev_q <= watchdog_kick_in;
            if (state_q != ST_RUN || kick_edge) begin
                wdog_q <= 16'h0000;
            end else if (!kick_driven && wdog_q >= WDOG_OPEN_LIMIT[`CNT_W-1:0]) begin
                wdog_q <= 16'h0000;
            end else if (tick_q && !wdog_expired) begin
                wdog_q <= wdog_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Reset state machine
    // ----------------------------------------------------------------
    // Our own drive of the line reads back as low; only count lows that the
    // mask lets through so the hold can finish and the release can settle.
    assign src_active = supply_low || mr_low_q || (line_low_in && !line_mask_q);

    // ----------------------------------------------------------------
    // Own-drive mask for the line input
    // ----------------------------------------------------------------
    // After we let go, the line needs a few cycles to climb past the enable
    // level; until then a low read-back is our own and must not restart reset.
    // Limitation: a processor pull that overlaps our own release is missed.
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            line_mask_q <= 1'b1;
        end else if (drive_low_q) begin
            line_mask_q <= 1'b1;
        end else if (line_above_enable) begin
            line_mask_q <= 1'b0;
        end
    end

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (src_active || wdog_expired) begin
                    state_d = ST_ASSERT;
                end
            end
            ST_ASSERT: begin
                if (!src_active) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (src_active) begin
                    state_d = ST_ASSERT;
                end else if (hold_q >= HOLD_LIMIT[`CNT_W-1:0]) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_ASSERT;
            end
        endcase
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_ASSERT;
            hold_q <= 16'h0000;
            drive_low_q <= 1'b1;
            reset_n_out <= 1'b0;
            reset_out <= 1'b1;
        end else begin
            state_q <= state_d;
            if (state_d != ST_HOLD) begin
                hold_q <= 16'h0000;
            end else if (tick_q) begin
                hold_q <= hold_q + 16'h0001;
            end
            drive_low_q <= (state_d != ST_RUN);
            reset_n_out <= (state_d == ST_RUN);
            reset_out <= (state_d != ST_RUN);
        end
    end

    // ----------------------------------------------------------------
    // Bidirectional line
    // ----------------------------------------------------------------
    // Line stays high via pullups unless we or the processor pull it low
    reset_line_pullup line_drv (
        .ref_clk(ref_clk),
        .reset(reset),
        .drive_low(drive_low_q),
        .line_low_in(line_low_in),
        .line_above_enable(line_above_enable),
        .line_above_upper(line_above_upper),
        .line_out(line_out),
        .line_oe(line_oe),
        .active_pullup_on(active_pullup_on),
        .passive_pullup_on(passive_pullup_on),
        .transition_armed(transition_armed)
    );
endmodule // supervisor_reset_watchdog

// [tb/sup_chk_asserts.sv]
// Port checker for the reset supervisor
`include "supervisor_consts.vh"
module sup_chk (
    input logic ref_clk,
    input logic reset,
    input logic supply_low,
    input logic manual_reset_n,
    input logic watchdog_kick_in,
    input logic kick_driven,
    input logic line_low_in,
    input logic line_above_enable,
    input logic line_above_upper,
    input logic reset_n_out,
    input logic reset_out,
    input logic line_out,
    input logic line_oe,
    input logic active_pullup_on,
    input logic passive_pullup_on,
    input logic transition_armed
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ----------
    // Helper counters: cycles without a kick edge, cycles of active pullup
    // ----------
    int wd_q;
    int ap_q;
    logic kick_q;
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wd_q <= 0;
            ap_q <= 0;
            kick_q <= 1'h0;
        end else begin
            kick_q <= watchdog_kick_in;
            ap_q <= active_pullup_on ? ap_q + 1 : 0;
            wd_q <= (!reset_n_out || !kick_driven || watchdog_kick_in != kick_q) ? 0 : wd_q + 1;
        end
    end
    sequence s_mr_low; (!manual_reset_n) [*4]; endsequence
    sequence s_glitch; reset_n_out && !supply_low ##1 !manual_reset_n ##1 manual_reset_n; endsequence
    property p_inv; reset_out == !reset_n_out; endproperty
    property p_uv; supply_low |-> ##2 !reset_n_out; endproperty
    property p_uv_hold; $fell(supply_low) |-> (!reset_n_out) [*8]; endproperty
    property p_mr; s_mr_low |-> ##[0:4] !reset_n_out; endproperty
    property p_glitch; s_glitch |-> reset_n_out [*4]; endproperty
    // The line driver follows the reset outputs by one cycle
    property p_oe; (line_oe == !$past(reset_n_out)) && !line_out; endproperty
    property p_pas; line_oe |-> !passive_pullup_on; endproperty
    property p_arm; line_low_in |=> transition_armed; endproperty
    property p_apon; transition_armed && line_above_enable && !line_above_upper && !line_oe |=> active_pullup_on;
    endproperty
    property p_apoff; active_pullup_on && line_above_upper |=> !active_pullup_on; endproperty
    property p_shot; ap_q <= `ONESHOT_CYC + 1; endproperty
    property p_wd; wd_q <= `WDOG_TICKS * `TICK_DIV + 3 * `TICK_DIV; endproperty
    a_inv: assert property (p_inv) else $error("outputs not inverse");
    a_uv: assert property (p_uv) else $error("no reset on low supply");
    a_uv_hold: assert property (p_uv_hold) else $error("supply hold cut short");
    a_mr: assert property (p_mr) else $error("no reset on manual input");
    a_glitch: assert property (p_glitch) else $error("glitch caused reset");
    a_oe: assert property (p_oe) else $error("line drive wrong");
    a_pas: assert property (p_pas) else $error("passive pullup on");
    a_arm: assert property (p_arm) else $error("flip-flop not set");
    a_apon: assert property (p_apon) else $error("active pullup not on");
    a_apoff: assert property (p_apoff) else $error("active pullup not off");
    a_shot: assert property (p_shot) else $error("one-shot too long");
    a_wd: assert property (p_wd) else $error("watchdog did not fire");
endmodule // sup_chk
bind supervisor_reset_watchdog sup_chk chk (
    .ref_clk(ref_clk),
    .reset(reset),
    .supply_low(supply_low),
    .manual_reset_n(manual_reset_n),
    .watchdog_kick_in(watchdog_kick_in),
    .kick_driven(kick_driven),
    .line_low_in(line_low_in),
    .line_above_enable(line_above_enable),
    .line_above_upper(line_above_upper),
    .reset_n_out(reset_n_out),
    .reset_out(reset_out),
    .line_out(line_out),
    .line_oe(line_oe),
    .active_pullup_on(active_pullup_on),
    .passive_pullup_on(passive_pullup_on),
    .transition_armed(transition_armed)
);

// [tb/line_model.sv]
// Behavioural shared reset line with the processor pin on it
module line_model (
    input logic ref_clk,
    input logic line_oe,
    input logic active_pullup_on,
    input logic proc_pull,
    output logic line_low_in,
    output logic line_above_enable,
    output logic line_above_upper
);
    timeunit 1ns;
    timeprecision 1ns;
    int lvl = 0;
    // Any puller wins; the active pullup charges the line four times faster.
    // Updating on the rising edge avoids racing the bench's falling-edge stimulus.
    always @(posedge ref_clk) begin
        if (line_oe || proc_pull) lvl <= 0;
        else if (lvl < 15) lvl <= lvl + (active_pullup_on ? 4 : 1);
    end
    assign line_low_in = lvl < 2;
    assign line_above_enable = lvl >= 2;
    assign line_above_upper = lvl >= 12;
endmodule // line_model

// [tb/supervisor_reset_watchdog_bench.sv]
// Self-checking bench for the reset supervisor
`include "supervisor_consts.vh"
module supervisor_reset_watchdog_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = `HOLD_TICKS * `TICK_DIV;
    localparam int WD = `WDOG_TICKS * `TICK_DIV;
    logic ref_clk = 0, reset = 1, supply_low = 0, manual_reset_n = 1;
    logic watchdog_kick_in = 0, kick_driven = 0, proc_pull = 0;
    logic line_low_in, line_above_enable, line_above_upper, reset_n_out, reset_out;
    logic line_out, line_oe, active_pullup_on, passive_pullup_on, transition_armed;
    int num_errors = 0, comparisons = 0;
    supervisor_reset_watchdog dut (
        .ref_clk(ref_clk),
        .reset(reset),
        .supply_low(supply_low),
        .manual_reset_n(manual_reset_n),
        .watchdog_kick_in(watchdog_kick_in),
        .kick_driven(kick_driven),
        .line_low_in(line_low_in),
        .line_above_enable(line_above_enable),
        .line_above_upper(line_above_upper),
        .reset_n_out(reset_n_out),
        .reset_out(reset_out),
        .line_out(line_out),
        .line_oe(line_oe),
        .active_pullup_on(active_pullup_on),
        .passive_pullup_on(passive_pullup_on),
        .transition_armed(transition_armed)
    );
    line_model far_end (
        .ref_clk(ref_clk),
        .line_oe(line_oe),
        .active_pullup_on(active_pullup_on),
        .proc_pull(proc_pull),
        .line_low_in(line_low_in),
        .line_above_enable(line_above_enable),
        .line_above_upper(line_above_upper)
    );
    initial forever #25 ref_clk = ~ref_clk;
    // ----------
    // Shared helpers
    // ----------
    task automatic chk(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("BAD %0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    task automatic wait_for(input logic v, input int max, output int n);
        n = 0;
        while (reset_n_out !== v && n < max) begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Source already cleared: hold count, then the pullup release sequence
    task automatic release_check;
        int n;
        logic seen;
        seen = 0;
        wait_for(1, HOLD + 200, n);
        chk_n(n, HOLD - 20, HOLD + 60);
        chk(reset_out, 0);
        // The line driver and passive pullup follow the reset outputs one cycle later
        cyc(1);
        chk(passive_pullup_on, 1);
        chk(line_oe, 0);
        repeat (20) begin
            @(negedge ref_clk);
            seen = seen | active_pullup_on;
        end
        chk(seen, 1);
        chk(active_pullup_on, 0);
        chk(line_above_upper, 1);
    endtask
    // ----------
    // Scenarios
    // ----------
    task automatic t_supply;
        supply_low = 1;
        cyc(3);
        chk(reset_n_out, 0);
        chk(reset_out, 1);
        chk(passive_pullup_on, 0);
        cyc(20);
        supply_low = 0;
        release_check();
        $display("test supply done");
    endtask
    task automatic t_manual;
        manual_reset_n = 0;
        cyc(1);
        manual_reset_n = 1;
        cyc(20);
        chk(reset_n_out, 1);
        manual_reset_n = 0;
        cyc(2);
        manual_reset_n = 1;
        cyc(20);
        chk(reset_n_out, 1);
        manual_reset_n = 0;
        cyc(40);
        chk(reset_n_out, 0);
        manual_reset_n = 1;
        release_check();
        $display("test manual done");
    endtask
    task automatic t_external;
        proc_pull = 1;
        cyc(4);
        chk(transition_armed, 1);
        proc_pull = 0;
        cyc(2);
        chk(line_low_in, 1);
        chk(reset_n_out, 0);
        release_check();
        $display("test external done");
    endtask
    task automatic t_open_kick;
        int n;
        wait_for(0, WD + 2000, n);
        chk_n(n, WD + 2000, WD + 2000);
        $display("test open_kick done");
    endtask
    task automatic t_watchdog;
        int n;
        kick_driven = 1;
        repeat (3) begin
            cyc(2000);
            watchdog_kick_in = ~watchdog_kick_in;
        end
        wait_for(0, WD + 200, n);
        chk_n(n, WD - 20, WD + 60);
        release_check();
        $display("test watchdog done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        cyc(3);
        reset = 0;
        release_check();
        $display("test power_up done");
        t_supply();
        t_manual();
        t_external();
        t_open_kick();
        t_watchdog();
        wrap_up();
    end
    initial begin
        #4800000;
        num_errors++;
        wrap_up();
    end
endmodule // supervisor_reset_watchdog_bench
